/* inc/adc_seq_pkg.sv */
// Package: register map, field layout, codes and timing of the auto-mode sequencer
package adc_seq_pkg;

  // Clock rates in MHz: system clock and converter reference
  localparam int CLK_MHZ = 125;
  localparam int REF_MHZ = 24;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_REFERENCE_SELECT  = 8'he7;
  localparam logic [7:0] IDX_MISC_INPUT_SEL    = 8'he8;
  localparam logic [7:0] IDX_LEFT_INPUT_SEL    = 8'he9;
  localparam logic [7:0] IDX_RIGHT_INPUT_SEL   = 8'hea;
  localparam logic [7:0] IDX_STEREO_RES        = 8'heb;
  localparam logic [7:0] IDX_DIFF_MISC_RES     = 8'hec;
  localparam logic [7:0] IDX_STEREO_SAMP_TIME  = 8'hed;
  localparam logic [7:0] IDX_MISC_SAMP_TIME    = 8'hee;
  localparam logic [7:0] IDX_MISC_CAPT_LOW     = 8'hef;
  localparam logic [7:0] IDX_STEREO_CAPT_LOW   = 8'hf0;
  localparam logic [7:0] IDX_STATE_LENGTHS     = 8'hf1;
  localparam logic [7:0] IDX_CHAN_EN_COUNT     = 8'hf2;
  localparam logic [7:0] IDX_RESULT_LOW        = 8'hf7;
  localparam logic [7:0] IDX_RESULT_HIGH       = 8'hf8;
  localparam logic [7:0] IDX_CONV_CLK_DIV      = 8'hf4;
  localparam logic [7:0] IDX_INPUT_SCALING     = 8'hfa;
  localparam logic [7:0] IDX_CONVERTER_POWER   = 8'hfc;

  // Register file spans the first to the last index; map marks stored slots
  localparam int          NSLOT  = 22;
  localparam logic [21:0] RW_MAP = 22'h282fff;

  // Reset values that differ from zero
  localparam logic [7:0] RST_STEREO_RES = 8'h33;
  localparam logic [7:0] RST_POWER      = 8'h20;

  // Field positions
  localparam int EN_LEFT_BIT   = 0;
  localparam int EN_RIGHT_BIT  = 1;
  localparam int EN_MISC_BIT   = 2;
  localparam int LAST_IDX_LSB  = 4;
  localparam int DIFF_LEFT_BIT = 4;
  localparam int POWER_DOWN_BIT = 5;
  localparam int SCALE_LSB     = 6;
  localparam int VALID_BIT     = 7;

  // Reference voltage codes: 0.6V, 0.9V, 1.2V; code 3 is reserved
  localparam logic [1:0] VREF_0P6 = 2'h0;
  localparam logic [1:0] VREF_0P9 = 2'h1;
  localparam logic [1:0] VREF_1P2 = 2'h2;

  // Sampling time: converter cycles = SAMP_STEP * (code + 1), 6/9/12 for 1/2/3
  localparam logic [5:0] SAMP_STEP = 6'h03;

  // Channel numbers
  typedef enum logic [1:0] {CH_LEFT = 2'h0, CH_RIGHT = 2'h1, CH_MISC = 2'h2} chan_e;

  // Converter control bundle, driven during each Set state
  typedef struct packed {
    logic [3:0] pos_sel;   // Positive input code
    logic [3:0] neg_sel;   // Negative input code
    logic       diff;      // Differential operation
    logic [1:0] vref;      // Reference select
    logic [1:0] res;       // Resolution select
    logic [3:0] tsamp;     // Sampling time code
    logic [5:0] settle;    // Sampling time in converter cycles
    logic [1:0] scale;     // Input scaling, zero is unity
  } conv_ctrl_s;

endpackage : adc_seq_pkg

/* rtl/adc_auto_mode_sequencer.sv */
// Auto-mode sequencer for a three-channel successive-approximation converter
//
// Overview of operation
// - Frame is sum of Set and Capture lengths
// - Converter clock is reference over divider plus one
// - Every Set state lasts shared 4-bit length
// - Left/right Capture lasts 10-bit stereo length
// - Misc Capture lasts 10-bit misc length
// - Bits 4..6 select differential per channel
// - Upper nibble positive, lower nibble negative input
// - Reference codes 0,1,2 give 0.6/0.9/1.2V
// - Resolution codes 1,2,3 give 10/12/14 bits
// - Sampling time codes 1,2,3 give 6/9/12 cycles
// - Scaling field zero selects unity scaling
// - Powered down after reset until bit cleared
// - Run pulse at Capture start, latch at end
// - Valid flag set at Capture end, self-clears
// - Right channel runs only with left enabled
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module adc_auto_mode_sequencer
  import adc_seq_pkg::*;
#(
  parameter int CLK_RATE_MHZ = adc_seq_pkg::CLK_MHZ,
  parameter int REF_RATE_MHZ = adc_seq_pkg::REF_MHZ
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [14:0]             conv_data,
  output adc_seq_pkg::conv_ctrl_s      conv_ctrl,
  output logic                         conv_run,
  output logic                         conv_clk_pulse,
  output logic                         converter_power_down,
  output logic                         result_valid_flag,
  output logic      [14:0]             result_data,
  output logic      [1:0]              result_chan
);
  import adc_seq_pkg::*;

  // Rates must let one reference tick fit in each system clock
  initial
  begin
    if (REF_RATE_MHZ >= CLK_RATE_MHZ || CLK_RATE_MHZ > 127)
      $error("adc_auto_mode_sequencer: unsupported clock rates");
  end

  localparam logic [7:0] REF_STEP = 8'(REF_RATE_MHZ);
  localparam logic [7:0] CLK_MOD  = 8'(CLK_RATE_MHZ);

  // Sequencer states
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_SET  = 3'b010,
    SQ_CAPT = 3'b100
  } seq_e;

  // Whole module state
  typedef struct packed {
    seq_e                  st;     // Sequencer state
    logic [2:0]            idx;    // State index
    logic [1:0]            ch;     // Channel of current pair
    logic [7:0]            acc;    // Reference tick phase
    logic                  tick;   // Reference tick
    logic [NSLOT-1:0][7:0] regs;   // Register file
    logic                  ready;  // Bus answer
    logic                  err;    // Bus error
    logic [31:0]           rdata;  // Bus read data
    conv_ctrl_s            ctl;    // Converter controls
    logic                  run;    // Conversion start
    logic                  valid;  // Result valid
    logic [14:0]           data;   // Latched result
    logic [1:0]            rch;    // Channel of result
  } seq_s;

  seq_s s_r;
  seq_s s_nxt;

  // Decoded fields
  logic       en_left;      // Left enabled
  logic       en_right;     // Right enabled, gated by left
  logic       en_misc;      // Misc enabled
  logic       any_en;       // Any channel enabled
  logic [2:0] last_idx;     // Last state index
  logic [3:0] set_len;      // Set state length
  logic [9:0] stereo_len;   // Stereo capture length
  logic [9:0] misc_len;     // Misc capture length
  logic       powered;      // Converter powered
  logic [2:0] clk_div;      // Converter clock divider

  // Timer handshake
  logic       tim_start;    // Load the timer
  logic [9:0] tim_len;      // Length to load
  logic       tim_done;     // State length elapsed

  // Bus decode
  logic [7:0] bus_idx;      // Register index
  logic [7:0] slot8;        // Slot offset from first index
  logic [4:0] slot;         // Slot in register file
  logic       in_file;      // Index within stored file
  logic       mapped;       // Address answers
  logic       setup;        // Setup phase
  logic       wr_take;      // Write takes effect

  // Register byte by index
  function automatic logic [7:0] reg_at(input seq_s s, input logic [7:0] i);
    logic [7:0] off;
    off = i - IDX_REFERENCE_SELECT;
    reg_at = s.regs[off[4:0]];
  endfunction : reg_at

  // Channel that owns the k-th Capture of the frame
  function automatic logic [1:0] chan_of(input logic [1:0] k, input logic l,
                                         input logic r, input logic m);
    logic [1:0] n;
    n = k;
    chan_of = CH_MISC;
    if (l)
    begin
      if (n == 2'h0)
        return CH_LEFT;
      n = n - 2'h1;
    end
    if (r)
    begin
      if (n == 2'h0)
        return CH_RIGHT;
      n = n - 2'h1;
    end
    if (m && n == 2'h0)
      return CH_MISC;
    // Past the enabled set: fall back to the first enabled channel
    if (l)
      chan_of = CH_LEFT;
    else if (m)
      chan_of = CH_MISC;
  endfunction : chan_of

  // Controls for one channel from its settings
  function automatic conv_ctrl_s ctl_of(input seq_s s, input logic [1:0] c);
    logic [7:0] sel;
    logic [7:0] vr;
    logic [7:0] dm;
    logic [7:0] tm;
    logic [1:0] vc;
    logic [7:0] rs;
    logic [7:0] sc;
    conv_ctrl_s o;
    vr = reg_at(s, IDX_REFERENCE_SELECT);
    dm = reg_at(s, IDX_DIFF_MISC_RES);
    rs = reg_at(s, IDX_STEREO_RES);
    sc = reg_at(s, IDX_INPUT_SCALING);
    o  = '0;
    unique case (c)
      CH_LEFT:
      begin
        sel   = reg_at(s, IDX_LEFT_INPUT_SEL);
        vc    = vr[1:0];
        o.res = rs[1:0];
        tm    = reg_at(s, IDX_STEREO_SAMP_TIME);
        o.tsamp = tm[3:0];
      end
      CH_RIGHT:
      begin
        sel   = reg_at(s, IDX_RIGHT_INPUT_SEL);
        vc    = vr[3:2];
        o.res = rs[5:4];
        tm    = reg_at(s, IDX_STEREO_SAMP_TIME);
        o.tsamp = tm[7:4];
      end
      default:
      begin
        sel   = reg_at(s, IDX_MISC_INPUT_SEL);
        vc    = vr[5:4];
        o.res = dm[1:0];
        tm    = reg_at(s, IDX_MISC_SAMP_TIME);
        o.tsamp = tm[3:0];
      end
    endcase
    o.pos_sel = sel[7:4];
    o.neg_sel = sel[3:0];
    o.diff    = dm[DIFF_LEFT_BIT + 32'(c)];
    // Reserved reference code falls back to the lowest reference
    o.vref    = (vc == VREF_0P6 || vc == VREF_0P9 || vc == VREF_1P2) ? vc : VREF_0P6;
    o.settle  = SAMP_STEP * (6'(o.tsamp) + 6'h01);
    o.scale   = sc[SCALE_LSB +: 2];
    return o;
  endfunction : ctl_of

  // Field decode from the register file
  always_comb
  begin
    en_left    = s_r.regs[IDX_CHAN_EN_COUNT - IDX_REFERENCE_SELECT][EN_LEFT_BIT];
    en_right   = s_r.regs[IDX_CHAN_EN_COUNT - IDX_REFERENCE_SELECT][EN_RIGHT_BIT]
                 && en_left;
    en_misc    = s_r.regs[IDX_CHAN_EN_COUNT - IDX_REFERENCE_SELECT][EN_MISC_BIT];
    any_en     = en_left || en_misc;
    last_idx   = s_r.regs[IDX_CHAN_EN_COUNT - IDX_REFERENCE_SELECT][LAST_IDX_LSB +: 3];
    set_len    = s_r.regs[IDX_STATE_LENGTHS - IDX_REFERENCE_SELECT][3:0];
    stereo_len = {s_r.regs[IDX_STATE_LENGTHS - IDX_REFERENCE_SELECT][5:4],
                  reg_at(s_r, IDX_STEREO_CAPT_LOW)};
    misc_len   = {s_r.regs[IDX_STATE_LENGTHS - IDX_REFERENCE_SELECT][7:6],
                  reg_at(s_r, IDX_MISC_CAPT_LOW)};
    powered    = !s_r.regs[IDX_CONVERTER_POWER - IDX_REFERENCE_SELECT][POWER_DOWN_BIT];
    clk_div    = s_r.regs[IDX_CONV_CLK_DIV - IDX_REFERENCE_SELECT][2:0];
  end

  // Bus address decode
  always_comb
  begin
    bus_idx = paddr[9:2];
    slot8   = bus_idx - IDX_REFERENCE_SELECT;
    slot    = slot8[4:0];
    in_file = (bus_idx >= IDX_REFERENCE_SELECT) && (bus_idx <= IDX_CONVERTER_POWER)
              && RW_MAP[slot];
    mapped  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
              && (in_file || bus_idx == IDX_RESULT_LOW || bus_idx == IDX_RESULT_HIGH);
    setup   = psel && !penable;
    wr_take = psel && penable && s_r.ready && pwrite && in_file && mapped;
  end

  // Next state of the whole module
  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.run = 1'b0;
    tim_start = 1'b0;
    tim_len   = 10'(set_len);

    // Reference tick from a phase accumulator
    s_nxt.tick = 1'b0;
    s_nxt.acc  = s_r.acc + REF_STEP;
    if (s_nxt.acc >= CLK_MOD)
    begin
      s_nxt.acc  = s_nxt.acc - CLK_MOD;
      s_nxt.tick = 1'b1;
    end

    // Bus: answer one cycle after setup, zero wait states
    s_nxt.ready = setup;
    s_nxt.err   = 1'b0;
    if (setup)
    begin
      s_nxt.err   = !mapped;
      s_nxt.rdata = '0;
      if (!pwrite && mapped)
      begin
        if (bus_idx == IDX_RESULT_LOW)
          s_nxt.rdata = {24'h000000, s_r.data[7:0]};
        else if (bus_idx == IDX_RESULT_HIGH)
          s_nxt.rdata = {24'h000000, s_r.valid, s_r.data[14:8]};
        else
          s_nxt.rdata = {24'h000000, s_r.regs[slot]};
      end
    end
    if (wr_take)
      s_nxt.regs[slot] = pwdata[7:0];

    // Valid flag clears on the next reference tick
    if (s_r.valid && s_r.tick)
      s_nxt.valid = 1'b0;

    // Sequencer
    unique case (s_r.st)
      SQ_IDLE:
      begin
        if (powered && any_en)
        begin
          s_nxt.st  = SQ_SET;
          s_nxt.idx = '0;
          s_nxt.ch  = chan_of(2'h0, en_left, en_right, en_misc);
          s_nxt.ctl = ctl_of(s_r, s_nxt.ch);
          tim_start = 1'b1;
        end
      end
      SQ_SET:
      begin
        if (tim_done)
        begin
          s_nxt.st  = SQ_CAPT;
          s_nxt.idx = s_r.idx + 3'h1;
          s_nxt.run = 1'b1;
          tim_start = 1'b1;
          tim_len   = (s_r.ch == CH_MISC) ? misc_len : stereo_len;
        end
      end
      SQ_CAPT:
      begin
        if (tim_done)
        begin
          s_nxt.data  = conv_data;
          s_nxt.rch   = s_r.ch;
          s_nxt.valid = 1'b1;
          // Wrap once the next index would reach the last one: the frame ends on a Capture
          s_nxt.idx   = (s_r.idx + 3'h1 >= last_idx) ? 3'h0 : s_r.idx + 3'h1;
          s_nxt.st    = SQ_SET;
          s_nxt.ch    = chan_of(s_nxt.idx[2:1], en_left, en_right, en_misc);
          s_nxt.ctl   = ctl_of(s_r, s_nxt.ch);
          tim_start   = 1'b1;
        end
      end
      default:
        s_nxt.st = SQ_IDLE;
    endcase

    // Power-down or no channel stops the frame
    if (!powered || !any_en)
    begin
      s_nxt.st  = SQ_IDLE;
      s_nxt.run = 1'b0;
      tim_start = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s_r       <= '0;
      s_r.st    <= SQ_IDLE;
      s_r.regs[IDX_STEREO_RES - IDX_REFERENCE_SELECT]     <= RST_STEREO_RES;
      s_r.regs[IDX_CONVERTER_POWER - IDX_REFERENCE_SELECT] <= RST_POWER;
    end
    else
      s_r <= s_nxt;
  end

  // State length timer
  state_timer #(
    .LEN_W (10)
  ) i_state_timer (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (tim_start),
    .len     (tim_len),
    .tick    (s_r.tick),
    .done    (tim_done)
  );

  // Converter clock from the reference
  conv_clk_div i_conv_clk_div (
    .ref_clk        (ref_clk),
    .rstn           (rstn),
    .enable         (powered),
    .tick           (s_r.tick),
    .div            (clk_div),
    .conv_clk_pulse (conv_clk_pulse)
  );

  // Outputs straight from flops
  assign prdata               = s_r.rdata;
  assign pready               = s_r.ready;
  assign pslverr              = s_r.err;
  assign conv_ctrl            = s_r.ctl;
  assign conv_run             = s_r.run;
  assign converter_power_down = s_r.regs[IDX_CONVERTER_POWER - IDX_REFERENCE_SELECT][POWER_DOWN_BIT];
  assign result_valid_flag    = s_r.valid;
  assign result_data          = s_r.data;
  assign result_chan          = s_r.rch;

endmodule : adc_auto_mode_sequencer
`default_nettype wire

/* rtl/conv_clk_div.sv */
// Converter clock divider: one pulse every div+1 reference ticks
`timescale 1ns/10ps
`default_nettype none
module conv_clk_div (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic [2:0] div,
  output logic            conv_clk_pulse
);
  typedef struct packed {
    logic [2:0] cnt;   // Ticks in current period
    logic       pulse; // Output pulse
  } div_s;

  div_s s_r;
  div_s s_nxt;

  assign conv_clk_pulse = s_r.pulse;

  // Count ticks up to the divider value, then pulse and wrap
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.pulse = 1'b0;
    if (!enable)
      s_nxt.cnt = '0;
    else if (tick)
    begin
      if (s_r.cnt >= div)
      begin
        s_nxt.cnt   = '0;
        s_nxt.pulse = 1'b1;
      end
      else
        s_nxt.cnt = s_r.cnt + 3'h1;
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule : conv_clk_div
`default_nettype wire

/* rtl/state_timer.sv */
// State length timer counting reference ticks
`timescale 1ns/10ps
`default_nettype none
module state_timer #(
  parameter int LEN_W = 10
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire logic [LEN_W-1:0] len,
  input  wire logic             tick,
  output logic                  done
);
  initial if (LEN_W < 4) $error("state_timer: LEN_W too small");

  typedef struct packed {
    logic [LEN_W-1:0] remain; // Reference ticks left
    logic             busy;   // Counting
  } tim_s;

  tim_s s_r;
  tim_s s_nxt;

  // Done in the cycle the last tick arrives
  assign done = s_r.busy && tick && (s_r.remain <= LEN_W'(1));

  // Load on start, count down on ticks; zero length acts as one
  always_comb
  begin
    s_nxt = s_r;
    if (start)
    begin
      s_nxt.busy   = 1'b1;
      s_nxt.remain = (len == '0) ? LEN_W'(1) : len;
    end
    else if (done)
      s_nxt.busy = 1'b0;
    else if (s_r.busy && tick)
      s_nxt.remain = s_r.remain - LEN_W'(1);
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule : state_timer
`default_nettype wire

/* tb/adc_auto_mode_sequencer_test.sv */
// Self-checking bench of the auto-mode sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_auto_mode_sequencer_test;
  import adc_seq_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [14:0] conv_data;
  conv_ctrl_s  conv_ctrl;
  logic        conv_run;
  logic        conv_clk_pulse;
  logic        converter_power_down;
  logic        result_valid_flag;
  logic [14:0] result_data;
  logic [1:0]  result_chan;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          run_at = 0;
  int          prev_at = 0;
  logic [7:0]  rd;
  logic        err;
  // Channel settings: index and value per write
  logic [15:0] tbl [13] = '{16'he724, 16'he8af, 16'he912, 16'hea34, 16'heb21,
    16'hec73, 16'hed21, 16'hee03, 16'hef0d, 16'hf014, 16'hf144, 16'hf405, 16'hfa00};
  // Expected result word and settle cycles, left, right, misc
  logic [14:0] exp_d [3] = '{15'h0944, 15'h1a58, 15'h57ec};
  logic [5:0]  exp_s [3] = '{6'h06, 6'h09, 6'h0c};

  adc_auto_mode_sequencer i_adc_auto_mode_sequencer (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_data(conv_data),
    .conv_ctrl(conv_ctrl), .conv_run(conv_run), .conv_clk_pulse(conv_clk_pulse),
    .converter_power_down(converter_power_down),
    .result_valid_flag(result_valid_flag), .result_data(result_data),
    .result_chan(result_chan)
  );
  conv_core_model i_conv_core_model (
    .ref_clk(ref_clk), .conv_ctrl(conv_ctrl), .conv_run(conv_run),
    .conv_data(conv_data)
  );

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  // Cycle count and hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end

  // Verdict and end of run
  task automatic conclude;
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Count a comparison, report a mismatch at once
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  // One APB transfer; byte address is four times the index
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    chk(n < 20, "no pready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  // Wait for run (0), valid (1) or converter clock (2)
  task automatic wait_on(input int k);
    int   n;
    logic s;
    n = 0;
    s = 1'b0;
    while (s !== 1'b1 && n < 3000)
    begin
      @(posedge ref_clk);
      n++;
      s = k == 0 ? conv_run : k == 1 ? result_valid_flag : conv_clk_pulse;
    end
    chk(n < 3000, "wait expired");
  endtask : wait_on

  // One capture of channel c: controls at run, result at valid
  task automatic run_chan(input int c);
    wait_on(0);
    prev_at = run_at;
    run_at = cyc;
    chk(conv_ctrl.settle === exp_s[c], "settle");
    wait_on(1);
    chk(result_chan === 2'(c), "channel");
    chk(result_data === exp_d[c], "result");
  endtask : run_chan

  // Run-to-run time against t ticks, k ticks of alignment allowed
  task automatic frame(input int t, input int k);
    int d;
    d = run_at - prev_at;
    chk(d >= t * CLK_MHZ / REF_MHZ - 6 && d <= (t + k) * CLK_MHZ / REF_MHZ + 6, "frame");
  endtask : frame

  // Restart the sequence with a new enable and last index
  task automatic mode(input logic [7:0] v);
    apb(1'b1, IDX_CHAN_EN_COUNT, 8'h00);
    apb(1'b1, IDX_CHAN_EN_COUNT, v);
  endtask : mode

  // Reset values, read-back, unmapped and read-only places
  task automatic t_regs;
    apb(1'b0, IDX_CONVERTER_POWER, 8'h00);
    chk(rd === RST_POWER && converter_power_down === 1'b1, "power reset");
    apb(1'b0, IDX_STEREO_RES, 8'h00);
    chk(rd === RST_STEREO_RES, "resolution reset");
    apb(1'b1, IDX_LEFT_INPUT_SEL, 8'h5c);
    apb(1'b0, IDX_LEFT_INPUT_SEL, 8'h00);
    chk(rd === 8'h5c, "read back");
    apb(1'b0, 8'hf3, 8'h00);
    chk(err === 1'b1 && rd === 8'h00, "unmapped");
    apb(1'b1, IDX_RESULT_HIGH, 8'hff);
    chk(err === 1'b0, "read-only write");
  endtask : t_regs

  // Mono after power-on, converter clock and frame length
  task automatic t_mono;
    int g;
    foreach (tbl[i]) apb(1'b1, tbl[i][15:8], tbl[i][7:0]);
    apb(1'b1, IDX_CONVERTER_POWER, 8'h00);
    mode(8'h21);
    wait_on(2);
    g = cyc;
    wait_on(2);
    chk(cyc - g >= 30 && cyc - g <= 33, "converter clock");
    run_chan(0);
    run_chan(0);
    frame(24, 2);
  endtask : t_mono

  // Stereo, three channels and misc alone
  task automatic t_multi;
    int t0;
    mode(8'h43);
    run_chan(0);
    run_chan(1);
    run_chan(0);
    mode(8'h67);
    run_chan(0);
    t0 = run_at;
    run_chan(1);
    run_chan(2);
    run_chan(0);
    prev_at = t0;
    frame(321, 6);
    mode(8'h24);
    run_chan(2);
    run_chan(2);
    frame(273, 2);
  endtask : t_multi

  // Right alone refused; power-down stops the run pulses
  task automatic t_refused;
    mode(8'h22);
    repeat (300) @(posedge ref_clk) chk(conv_run === 1'b0, "right alone ran");
    mode(8'h21);
    apb(1'b1, IDX_CONVERTER_POWER, 8'h20);
    chk(converter_power_down === 1'b1, "power down");
    repeat (300) @(posedge ref_clk) chk(conv_run === 1'b0, "ran powered down");
  endtask : t_refused

  // Main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_mono();
    t_multi();
    t_refused();
    conclude();
  end
endmodule : adc_auto_mode_sequencer_test
`default_nettype wire

/* tb/adc_seq_chk.sv */
// Port checker of the auto-mode sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_seq_chk
  import adc_seq_pkg::*;
#(
  parameter int CLK_RATE_MHZ = 125,
  parameter int REF_RATE_MHZ = 24
) (
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [14:0]             conv_data,
  input wire adc_seq_pkg::conv_ctrl_s conv_ctrl,
  input wire logic                    conv_run,
  input wire logic                    conv_clk_pulse,
  input wire logic                    converter_power_down,
  input wire logic                    result_valid_flag,
  input wire logic [14:0]             result_data
);
  // One clock domain, checks idle in reset except AST_PD_RESET
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Bus answers in the cycle after setup, for one cycle only
  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("pready late");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_READ_BYTE: assert property (pready |-> prdata[31:8] == 24'h0 && !(pslverr && prdata != 0))
    else $error("read data bad");
  // Reset leaves the converter powered down
  AST_PD_RESET: assert property (disable iff (1'b0) !rstn |=> converter_power_down)
    else $error("not powered down");
  AST_PD_QUIET: assert property (converter_power_down && $past(converter_power_down)
    |-> !conv_run && !conv_clk_pulse)
    else $error("activity while powered down");
  // Pulses are single and spaced by at least one tick
  AST_RUN_ONE: assert property (conv_run |=> !conv_run [*4])
    else $error("run pulse too long");
  AST_CLK_GAP: assert property (conv_clk_pulse |=> !conv_clk_pulse [*4])
    else $error("converter clock too fast");
  // Valid flag clears by itself within one tick
  AST_VALID_CLEAR: assert property (result_valid_flag |-> ##[1:7] !result_valid_flag)
    else $error("valid flag stuck");
  AST_RESULT_LATCH: assert property ($rose(result_valid_flag) |-> result_data == $past(conv_data))
    else $error("result not latched");
  AST_CTRL_HOLD: assert property (conv_run |-> $stable(conv_ctrl))
    else $error("controls moved at capture start");
  // Main scenarios reached
  COV_RUN: cover property (conv_run);
  COV_VALID: cover property ($rose(result_valid_flag));
  COV_ERR: cover property (pslverr);
  COV_CLK: cover property (conv_clk_pulse);
endmodule : adc_seq_chk
bind adc_auto_mode_sequencer adc_seq_chk #(
  .CLK_RATE_MHZ(CLK_RATE_MHZ),
  .REF_RATE_MHZ(REF_RATE_MHZ)
) i_adc_seq_chk (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_data(conv_data),
  .conv_ctrl(conv_ctrl), .conv_run(conv_run), .conv_clk_pulse(conv_clk_pulse),
  .converter_power_down(converter_power_down), .result_valid_flag(result_valid_flag),
  .result_data(result_data)
);
`default_nettype wire

/* tb/conv_core_model.sv */
// Behavioural converter core answering run pulses
`timescale 1ns/10ps
`default_nettype none
module conv_core_model
  import adc_seq_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire adc_seq_pkg::conv_ctrl_s conv_ctrl,
  input  wire logic                    conv_run,
  output var logic [14:0]              conv_data
);
  // Output register holds an odd pattern until the first conversion
  initial conv_data = 15'h2aaa;
  // A run pulse starts a conversion; the word encodes the settings seen
  always @(posedge ref_clk)
  begin
    if (conv_run)
    begin
      conv_data <= {conv_ctrl.pos_sel, conv_ctrl.neg_sel, conv_ctrl.diff,
                    conv_ctrl.vref, conv_ctrl.res, conv_ctrl.scale};
    end
  end
endmodule : conv_core_model
`default_nettype wire
